// ===== core/expander_pkg.sv
package expander_pkg;
   localparam int          BYTE_BITS      = 8;
   localparam int          PORT_BITS      = 16;
   localparam logic [3:0]  ADDR_FIXED     = 4'h4;
   localparam logic [6:0]  GENERAL_CALL   = 7'h00;
   localparam logic [7:0]  WRITE_ADDR_MIN = 8'h40;
   localparam logic [7:0]  WRITE_ADDR_MAX = 8'h4e;
   localparam logic [7:0]  READ_ADDR_MAX  = 8'h4f;
   localparam logic [3:0]  ACK_SLOT       = 4'h8;
   localparam logic [3:0]  BIT_STEP       = 4'h1;
   localparam logic [1:0]  PRIME_DONE     = 2'h3;
   localparam logic [1:0]  PRIME_STEP     = 2'h1;
   localparam logic [15:0] PORT_RESET     = 16'hffff;

   typedef enum logic [3:0] {
      L_ADDR   = 4'b0001,
      L_WRITE  = 4'b0010,
      L_READ   = 4'b0100,
      L_IGNORE = 4'b1000
   } link_state_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } port_word_t;

   typedef struct packed {
      link_state_t st;
      logic [3:0]  bitcnt;
      logic [7:0]  shift;
      logic        pair_hi;
      logic [7:0]  lo_hold;
      logic [7:0]  rd_byte;
   } link_ctl_t;

   typedef struct packed {
      logic [2:0] sel_s1;
      logic [2:0] sel_s2;
      port_word_t in_s1;
      port_word_t in_s2;
      port_word_t wr_word;
      logic       wr_tgl;
      logic       ack_tgl;
   } link_keep_t;

   typedef struct packed {
      logic       scl_s1;
      logic       scl_s2;
      logic       sda_s1;
      logic       sda_s2;
      logic       sda_d;
      logic       idle;
      logic       frame_rst;
      logic       wr_s1;
      logic       wr_s2;
      logic       wr_d;
      logic       ack_s1;
      logic       ack_s2;
      logic       ack_d;
      port_word_t latch;
      port_word_t drive_low;
      port_word_t in_s1;
      port_word_t in_s2;
      port_word_t snap;
      logic [1:0] prime;
      logic       alert_n;
      logic       alert_oe;
   } sys_t;

   function automatic logic addr_match(input logic [7:0] a,
                                       input logic [2:0] sel);
      addr_match = (a[7:4] == ADDR_FIXED) && (a[3:1] == sel)
                   && (a[7:1] != GENERAL_CALL);
   endfunction
endpackage

// ===== core/port_expander.sv
`timescale 1ns/1ps
module port_expander #(
   parameter int PORT_WIDTH = 16
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic [2:0] addr_sel_in,
   input  wire logic [7:0] low_byte_port_lines_in,
   output logic      [7:0] low_byte_port_lines_out,
   output logic      [7:0] low_byte_port_lines_oe_out,
   input  wire logic [7:0] high_byte_port_lines_in,
   output logic      [7:0] high_byte_port_lines_out,
   output logic      [7:0] high_byte_port_lines_oe_out,
   output logic            change_alert_n_out,
   output logic            change_alert_oe_out
);
   if (PORT_WIDTH != expander_pkg::PORT_BITS)
   begin
      $error("port_expander serves exactly two port bytes");
   end

   expander_pkg::sys_t      s_reg;
   expander_pkg::sys_t      s_next;
   expander_pkg::link_ctl_t c_reg;
   expander_pkg::link_ctl_t c_next;
   expander_pkg::link_keep_t k_reg;
   expander_pkg::link_keep_t k_next;
   logic                    sda_oe_reg;
   logic                    sda_drive;
   logic                    wr_commit;
   logic                    ack_evt;
   logic                    start_seen;
   logic                    stop_seen;
   expander_pkg::port_word_t change;

   // System clock side: bus framing, port latch, change alert
   always_comb
   begin
      s_next        = s_reg;
      s_next.scl_s1 = scl_in;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.sda_s1 = sda_in;
      s_next.sda_s2 = s_reg.sda_s1;
      s_next.sda_d  = s_reg.sda_s2;
      s_next.wr_s1  = k_reg.wr_tgl;
      s_next.wr_s2  = s_reg.wr_s1;
      s_next.wr_d   = s_reg.wr_s2;
      s_next.ack_s1 = k_reg.ack_tgl;
      s_next.ack_s2 = s_reg.ack_s1;
      s_next.ack_d  = s_reg.ack_s2;
      s_next.in_s1  = {high_byte_port_lines_in, low_byte_port_lines_in};
      s_next.in_s2  = s_reg.in_s1;
      start_seen = s_reg.scl_s2 && s_reg.sda_d && !s_reg.sda_s2;
      stop_seen  = s_reg.scl_s2 && !s_reg.sda_d && s_reg.sda_s2;
      if (start_seen)
         s_next.idle = 1'b0;
      else if (stop_seen)
         s_next.idle = 1'b1;
      // A repeated start also restarts the link logic
      s_next.frame_rst = s_next.idle || start_seen;
      if (s_reg.wr_s2 != s_reg.wr_d)
      begin
         s_next.latch     = k_reg.wr_word;
         s_next.drive_low = ~k_reg.wr_word;
      end
      // Rearm after ack, past own port update
      if (s_reg.ack_s2 != s_reg.ack_d)
         s_next.prime = '0;
      else if (s_reg.prime != expander_pkg::PRIME_DONE)
         s_next.prime = s_reg.prime + expander_pkg::PRIME_STEP;
      if (s_reg.prime != expander_pkg::PRIME_DONE)
         s_next.snap = s_reg.in_s2;
      // Only lines left high act as inputs
      change           = (s_reg.prime == expander_pkg::PRIME_DONE)
                         ? (s_reg.in_s2 ^ s_reg.snap) & s_reg.latch : '0;
      s_next.alert_n   = ~(|change);
      s_next.alert_oe  = |change;
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s_reg           <= '0;
         s_reg.scl_s1    <= 1'b1;
         s_reg.scl_s2    <= 1'b1;
         s_reg.sda_s1    <= 1'b1;
         s_reg.sda_s2    <= 1'b1;
         s_reg.sda_d     <= 1'b1;
         s_reg.idle      <= 1'b1;
         s_reg.frame_rst <= 1'b1;
         s_reg.latch     <= expander_pkg::PORT_RESET;
         s_reg.alert_n   <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // Link side: shift engine on SCL rising edges
   always_comb
   begin
      c_next    = c_reg;
      wr_commit = 1'b0;
      ack_evt   = 1'b0;
      unique case (c_reg.st)
         expander_pkg::L_ADDR:
         begin
            if (c_reg.bitcnt == expander_pkg::ACK_SLOT)
            begin
               c_next.bitcnt = '0;
               if (expander_pkg::addr_match(c_reg.shift, k_reg.sel_s2))
               begin
                  ack_evt        = 1'b1;
                  c_next.pair_hi = 1'b0;
                  c_next.rd_byte = k_reg.in_s2.lo;
                  // Bit 0 picks read or write
                  c_next.st      = c_reg.shift[0] ? expander_pkg::L_READ
                                                  : expander_pkg::L_WRITE;
               end
               else
                  c_next.st = expander_pkg::L_IGNORE;
            end
            else
            begin
               c_next.shift  = {c_reg.shift[6:0], sda_in};
               c_next.bitcnt = c_reg.bitcnt + expander_pkg::BIT_STEP;
            end
         end
         expander_pkg::L_WRITE:
         begin
            if (c_reg.bitcnt == expander_pkg::ACK_SLOT)
            begin
               c_next.bitcnt  = '0;
               c_next.pair_hi = !c_reg.pair_hi;
               ack_evt        = 1'b1;
               if (!c_reg.pair_hi)
                  c_next.lo_hold = c_reg.shift;
               else
                  wr_commit = 1'b1;
            end
            else
            begin
               c_next.shift  = {c_reg.shift[6:0], sda_in};
               c_next.bitcnt = c_reg.bitcnt + expander_pkg::BIT_STEP;
            end
         end
         expander_pkg::L_READ:
         begin
            if (c_reg.bitcnt == expander_pkg::ACK_SLOT)
            begin
               c_next.bitcnt = '0;
               // Master nack ends our part of the read
               if (sda_in)
                  c_next.st = expander_pkg::L_IGNORE;
               else
               begin
                  ack_evt        = 1'b1;
                  c_next.pair_hi = !c_reg.pair_hi;
                  c_next.rd_byte = c_reg.pair_hi ? k_reg.in_s2.lo
                                                 : k_reg.in_s2.hi;
               end
            end
            else
            begin
               c_next.rd_byte = {c_reg.rd_byte[6:0], 1'b0};
               c_next.bitcnt  = c_reg.bitcnt + expander_pkg::BIT_STEP;
            end
         end
         expander_pkg::L_IGNORE:
            c_next = c_reg;
      endcase
   end

   always_comb
   begin
      k_next        = k_reg;
      k_next.sel_s1 = addr_sel_in;
      k_next.sel_s2 = k_reg.sel_s1;
      k_next.in_s1  = {high_byte_port_lines_in, low_byte_port_lines_in};
      k_next.in_s2  = k_reg.in_s1;
      if (wr_commit)
      begin
         k_next.wr_word = {c_reg.shift, c_reg.lo_hold};
         k_next.wr_tgl  = !k_reg.wr_tgl;
      end
      if (ack_evt)
         k_next.ack_tgl = !k_reg.ack_tgl;
   end

   // Frame control is cleared by the framing logic between frames
   always_ff @(posedge scl_in or posedge s_reg.frame_rst)
   begin
      if (s_reg.frame_rst)
      begin
         c_reg    <= '0;
         c_reg.st <= expander_pkg::L_ADDR;
      end
      else
         c_reg <= c_next;
   end

   // Toggles survive frame ends, else a stop fakes an event
   always_ff @(posedge scl_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         k_reg         <= '0;
         k_reg.in_s1   <= expander_pkg::PORT_RESET;
         k_reg.in_s2   <= expander_pkg::PORT_RESET;
         k_reg.wr_word <= expander_pkg::PORT_RESET;
      end
      else
         k_reg <= k_next;
   end

   // SDA changes only while SCL is low
   always_comb
   begin
      sda_drive = 1'b0;
      unique case (c_reg.st)
         expander_pkg::L_ADDR:
            sda_drive = (c_reg.bitcnt == expander_pkg::ACK_SLOT)
               && expander_pkg::addr_match(c_reg.shift, k_reg.sel_s2);
         expander_pkg::L_WRITE:
            sda_drive = (c_reg.bitcnt == expander_pkg::ACK_SLOT);
         expander_pkg::L_READ:
            sda_drive = (c_reg.bitcnt != expander_pkg::ACK_SLOT)
                        && !c_reg.rd_byte[7];
         expander_pkg::L_IGNORE:
            sda_drive = 1'b0;
      endcase
   end

   always_ff @(negedge scl_in or posedge s_reg.frame_rst)
   begin
      if (s_reg.frame_rst)
         sda_oe_reg <= 1'b0;
      else
         sda_oe_reg <= sda_drive;
   end

   assign sda_out                     = 1'b0;
   assign sda_oe_out                  = sda_oe_reg;
   assign low_byte_port_lines_out     = s_reg.latch.lo;
   assign low_byte_port_lines_oe_out  = s_reg.drive_low.lo;
   assign high_byte_port_lines_out    = s_reg.latch.hi;
   assign high_byte_port_lines_oe_out = s_reg.drive_low.hi;
   assign change_alert_n_out          = s_reg.alert_n;
   assign change_alert_oe_out         = s_reg.alert_oe;

   chk_addr_pattern: assert property (
      @(posedge scl_in) disable iff (s_reg.frame_rst)
      (c_reg.st == expander_pkg::L_ADDR && c_next.st != expander_pkg::L_ADDR
       && c_next.st != expander_pkg::L_IGNORE)
      |-> c_reg.shift[7:4] == expander_pkg::ADDR_FIXED)
      else $error("address accepted without fixed pattern");
   chk_sel_match: assert property (
      @(posedge scl_in) disable iff (s_reg.frame_rst)
      (c_reg.st == expander_pkg::L_ADDR
       && c_reg.bitcnt == expander_pkg::ACK_SLOT
       && c_reg.shift[3:1] != k_reg.sel_s2)
      |=> c_reg.st == expander_pkg::L_IGNORE)
      else $error("foreign address not ignored");
   chk_write_range: assert property (
      @(posedge scl_in) disable iff (s_reg.frame_rst)
      (c_reg.st == expander_pkg::L_ADDR && c_next.st == expander_pkg::L_WRITE)
      |-> c_reg.shift >= expander_pkg::WRITE_ADDR_MIN
          && c_reg.shift <= expander_pkg::WRITE_ADDR_MAX)
      else $error("write address out of range");
   chk_gc_silent: assert property (
      @(negedge scl_in) disable iff (s_reg.frame_rst)
      (c_reg.st == expander_pkg::L_ADDR
       && c_reg.bitcnt == expander_pkg::ACK_SLOT
       && c_reg.shift[7:1] == expander_pkg::GENERAL_CALL)
      |=> !sda_oe_reg)
      else $error("general call acknowledged");
   chk_read_levels: assert property (
      @(posedge scl_in) disable iff (s_reg.frame_rst)
      (c_reg.st == expander_pkg::L_READ && !sda_in && !c_reg.pair_hi
       && c_reg.bitcnt == expander_pkg::ACK_SLOT)
      |=> c_reg.rd_byte == $past(k_reg.in_s2.hi))
      else $error("read byte not port levels");
   chk_low_map: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_reg.wr_s2 != s_reg.wr_d)
      |=> s_reg.latch.lo == $past(k_reg.wr_word.lo)
          && s_reg.drive_low.lo == ~s_reg.latch.lo)
      else $error("low byte mapping wrong");
   chk_high_map: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_reg.wr_s2 != s_reg.wr_d)
      |=> s_reg.latch.hi == $past(k_reg.wr_word.hi))
      else $error("high byte mapping wrong");
   chk_latch_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_reg.wr_s2 == s_reg.wr_d) |=> $stable(s_reg.latch))
      else $error("port changed without complete pair");
   chk_alert_set: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_reg.prime == expander_pkg::PRIME_DONE
       && |((s_reg.in_s2 ^ s_reg.snap) & s_reg.latch))
      |=> !change_alert_n_out && change_alert_oe_out)
      else $error("input change did not raise alert");
   chk_reset_state: assert property (
      @(posedge clk_in)
      reset_in |-> s_reg.latch == expander_pkg::PORT_RESET
                   && s_reg.drive_low == '0 && s_reg.frame_rst)
      else $error("reset defaults not applied");
endmodule

// ===== tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   // Extra low time per bit, for a slow master
   int pause_ns = 0;

   initial
   begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic start_c();
      sda_oe_out = 1'b0;
      scl_out = 1'b1;
      #107 sda_oe_out = 1'b1;
      // Long hold so the sync flops see the start first
      #120 scl_out = 1'b0;
      #20;
   endtask

   task automatic stop_c();
      sda_oe_out = 1'b1;
      #20 scl_out = 1'b1;
      #60 sda_oe_out = 1'b0;
      #100;
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ninth,
                          output logic [7:0] rx, output logic acked);
      logic [8:0] frame;
      logic [8:0] got;
      frame = {tx, ninth};
      got = 9'h000;
      for (int i = 8; i >= 0; i--)
      begin
         sda_oe_out = ~frame[i];
         #(20 + pause_ns) scl_out = 1'b1;
         #40 got = {got[7:0], sda_in};
         scl_out = 1'b0;
         #20;
      end
      rx = got[8:1];
      acked = ~got[0];
   endtask
endmodule

// ===== tb/i2c_expander_addressing_por_tb.sv
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module i2c_expander_addressing_por_tb;
   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] ext_lo;
      logic [7:0] ext_hi;
   } row_t;
   row_t rows [8] = '{
      '{3'h0, 8'h12, 8'h34, 8'hff, 8'hff}, '{3'h1, 8'ha5, 8'h5a, 8'h0f, 8'hf0},
      '{3'h2, 8'hff, 8'h00, 8'h3c, 8'hff}, '{3'h3, 8'h00, 8'hff, 8'hff, 8'hc3},
      '{3'h4, 8'h80, 8'h01, 8'h7f, 8'hfe}, '{3'h5, 8'h01, 8'h80, 8'hfe, 8'h7f},
      '{3'h6, 8'hff, 8'hff, 8'h55, 8'haa}, '{3'h7, 8'hc3, 8'h3c, 8'hff, 8'hff}};
   logic        clk_in   = 1'b0;
   logic        reset_in = 1'b0;
   logic [2:0]  addr_sel = 3'h0;
   logic [7:0]  ext_lo   = 8'hff;
   logic [7:0]  ext_hi   = 8'hff;
   logic        m_scl, m_oe, dut_sda, dut_oe, alert_n, alert_oe, ack;
   logic [7:0]  lo_out, lo_oe, hi_out, hi_oe, rx, lo_pin, hi_pin;
   logic [15:0] w;
   logic        sda;
   int          errors = 0;
   int          total_checks = 0;

   // Open-drain wires with pull-ups
   assign sda = ~m_oe & (dut_oe ? dut_sda : 1'b1);
   assign lo_pin = ext_lo & ~lo_oe;
   assign hi_pin = ext_hi & ~hi_oe;

   always #5 clk_in = ~clk_in;

   i2c_master_model m (.sda_in(sda), .scl_out(m_scl), .sda_oe_out(m_oe));

   port_expander uut (
      .clk_in(clk_in), .reset_in(reset_in), .scl_in(m_scl), .sda_in(sda),
      .sda_out(dut_sda), .sda_oe_out(dut_oe), .addr_sel_in(addr_sel),
      .low_byte_port_lines_in(lo_pin), .low_byte_port_lines_out(lo_out),
      .low_byte_port_lines_oe_out(lo_oe), .high_byte_port_lines_in(hi_pin),
      .high_byte_port_lines_out(hi_out), .high_byte_port_lines_oe_out(hi_oe),
      .change_alert_n_out(alert_n), .change_alert_oe_out(alert_oe));

   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic send(input logic [7:0] a, input logic [23:0] d,
                       input int nb, input logic exp);
      m.start_c();
      m.byte_io(a, 1'b1, rx, ack);
      `CHECK(ack, exp)
      for (int k = 0; k < nb; k++)
      begin
         m.byte_io(d[23 - 8 * k -: 8], 1'b1, rx, ack);
         `CHECK(ack, exp)
      end
      m.stop_c();
      tick(8);
   endtask

   task automatic rd(input logic [7:0] a);
      m.start_c();
      m.byte_io(a, 1'b1, rx, ack);
      `CHECK(ack, 1'b1)
      m.byte_io(8'hff, 1'b0, rx, ack);
      w[7:0] = rx;
      m.byte_io(8'hff, 1'b1, rx, ack);
      w[15:8] = rx;
      m.stop_c();
      tick(8);
   endtask

   task automatic idle_check();
      `CHECK({hi_out, lo_out}, 16'hffff)
      `CHECK({hi_oe, lo_oe}, 16'h0000)
      `CHECK({alert_n, alert_oe, dut_oe}, 3'b100)
   endtask

   // 24 frames, about 75 us in all; ample margin
   initial
   begin
      #400us;
      errors++;
      tally_and_finish();
   end

   initial
   begin
      // A real rising edge, so the async reset fires at time zero
      reset_in = 1'b1;
      tick(6);
      reset_in = 1'b0;
      idle_check();
      tick(4);
      foreach (rows[i])
      begin
         addr_sel = rows[i].sel;
         ext_lo = rows[i].ext_lo;
         ext_hi = rows[i].ext_hi;
         tick(2);
         send({4'h4, rows[i].sel, 1'b0}, {rows[i].lo, rows[i].hi, 8'h00},
              2, 1'b1);
         `CHECK(lo_out, rows[i].lo)
         `CHECK(hi_out, rows[i].hi)
         `CHECK({hi_oe, lo_oe}, ~{rows[i].hi, rows[i].lo})
         rd({4'h4, rows[i].sel, 1'b1});
         `CHECK(w, {rows[i].hi & rows[i].ext_hi, rows[i].lo & rows[i].ext_lo})
         `CHECK(alert_n, 1'b1)
      end
      addr_sel = 3'h0;
      ext_hi = 8'hff;
      tick(2);
      send(8'h42, 24'h0000_00, 2, 1'b0);
      `CHECK({hi_out, lo_out}, 16'h3cc3)
      send(8'h00, 24'h0000_00, 1, 1'b0);
      `CHECK({hi_out, lo_out}, 16'h3cc3)
      m.pause_ns = 200;
      send(8'h40, 24'h9900_00, 1, 1'b1);
      `CHECK({hi_out, lo_out}, 16'h3cc3)
      send(8'h40, 24'h1122_33, 3, 1'b1);
      `CHECK({hi_out, lo_out}, 16'h2211)
      m.pause_ns = 0;
      send(8'h40, 24'h4455_00, 2, 1'b1);
      `CHECK({hi_out, lo_out}, 16'h5544)
      send(8'h40, 24'hffff_00, 2, 1'b1);
      tick(10);
      `CHECK(alert_n, 1'b1)
      ext_lo = 8'hfe;
      tick(8);
      `CHECK({alert_n, alert_oe}, 2'b01)
      ext_lo = 8'hff;
      tick(8);
      `CHECK({alert_n, alert_oe}, 2'b10)
      ext_hi = 8'h7f;
      tick(8);
      `CHECK(alert_n, 1'b0)
      rd(8'h41);
      `CHECK(alert_n, 1'b1)
      `CHECK(w, 16'h7fff)
      reset_in = 1'b1;
      tick(2);
      idle_check();
      reset_in = 1'b0;
      tick(4);
      send(8'h40, 24'habcd_00, 2, 1'b1);
      `CHECK({hi_out, lo_out}, 16'hcdab)
      tally_and_finish();
   end
endmodule
